/* File: sbc_controller.sv */
`timescale 1ns/10ps
`default_nettype none
module sbc_controller (
  // System clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_write,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Timer overflow pulses: timer 0, timer 1, timer 2 high, timer 2 low
  input wire logic [3:0] i_timer_overflow,
  // Status to the rest of the chip
  output logic o_timer3_reload,
  output logic o_bus_error,
  // Bus side, running on the link clock
  input wire logic i_link_clock,
  input wire logic i_scl_in,
  input wire logic i_sda_in,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe
);
  import sbc_pkg::*;

  // ************************************************************
  // Link clock domain
  // ************************************************************
  logic lrst_meta_r;
  logic lrst_r;
  sbc_lines_type pin_meta_r;
  sbc_lines_type pin_sync_r;
  sbc_lines_type pin_prev_r;
  sbc_lines_type drive_meta_r;
  sbc_lines_type drive_sync_r;
  logic begin_toggle_r;
  logic halt_toggle_r;
  logic line_begin;
  logic line_halt;
  // System-side state, declared here because the drive synchroniser reads it
  sbc_core_type core_r;

  // Reset crosses into the link domain through two stages
  always_ff @(posedge i_link_clock) begin
    lrst_meta_r <= i_reset;
    lrst_r <= lrst_meta_r;
  end

  // Pin and drive synchronisers; first stages feed only second stages
  always_ff @(posedge i_link_clock) begin
    if (lrst_r) begin
      pin_meta_r <= 2'h3;
      pin_sync_r <= 2'h3;
      pin_prev_r <= 2'h3;
      drive_meta_r <= 2'h0;
      drive_sync_r <= 2'h0;
    end else begin
      pin_meta_r <= {i_scl_in, i_sda_in};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      drive_meta_r <= {core_r.scl_pull, core_r.sda_pull};
      drive_sync_r <= drive_meta_r;
    end
  end

  // Conditions: data line moves while the clock line stays high
  assign line_begin = pin_sync_r.scl & pin_prev_r.scl & pin_prev_r.sda & ~pin_sync_r.sda;
  assign line_halt = pin_sync_r.scl & pin_prev_r.scl & ~pin_prev_r.sda & pin_sync_r.sda;

  // Events leave the link domain as toggles
  always_ff @(posedge i_link_clock) begin
    if (lrst_r) begin
      begin_toggle_r <= 1'b0;
      halt_toggle_r <= 1'b0;
    end else begin
      begin_toggle_r <= begin_toggle_r ^ line_begin;
      halt_toggle_r <= halt_toggle_r ^ line_halt;
    end
  end

  // Open-drain pins: output level is always low, enable pulls the line
  always_ff @(posedge i_link_clock) begin
    if (lrst_r) begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_scl_oe <= drive_sync_r.scl;
      o_sda_oe <= drive_sync_r.sda;
    end
  end

  // ************************************************************
  // Crossing into the system domain
  // ************************************************************
  sbc_lines_type lvl_meta_r;
  sbc_lines_type lvl_r;
  logic [1:0] tog_meta_r;
  logic [1:0] tog_sync_r;
  logic [1:0] tog_prev_r;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      lvl_meta_r <= 2'h3;
      lvl_r <= 2'h3;
      tog_meta_r <= 2'h0;
      tog_sync_r <= 2'h0;
      tog_prev_r <= 2'h0;
    end else begin
      lvl_meta_r <= pin_sync_r;
      lvl_r <= lvl_meta_r;
      tog_meta_r <= {begin_toggle_r, halt_toggle_r};
      tog_sync_r <= tog_meta_r;
      tog_prev_r <= tog_sync_r;
    end
  end

  // ************************************************************
  // Decode and event wires
  // ************************************************************
  sbc_core_type core_nxt;
  sbc_control_type ctl_wdata;
  sbc_config_type cfg_wdata;
  sbc_control_type ctl_view;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic write_ctl;
  logic write_cfg;
  logic write_data;
  logic irq_clear;
  logic tick;
  logic begin_ev;
  logic halt_ev;
  logic lines_high;
  logic free_ev;
  logic [4:0] hold_len;
  logic [4:0] setup_len;
  logic bit_one;

  assign ctl_wdata = sbc_control_type'(i_sfr_wdata);
  assign cfg_wdata = sbc_config_type'(i_sfr_wdata);
  assign write_ctl = i_sfr_write & (i_sfr_addr == SBC_CONTROL_ADDR);
  assign write_cfg = i_sfr_write & (i_sfr_addr == SBC_CONFIG_ADDR);
  assign write_data = i_sfr_write & (i_sfr_addr == SBC_DATA_ADDR);
  assign irq_clear = write_ctl & ~ctl_wdata.irq_flag & core_r.ctl.irq_flag;
  assign tick = i_timer_overflow[core_r.cfg.bit_clock_select];
  assign begin_ev = tog_sync_r[1] ^ tog_prev_r[1];
  assign halt_ev = tog_sync_r[0] ^ tog_prev_r[0];
  assign lines_high = lvl_r.scl & lvl_r.sda;
  assign free_ev = core_r.cfg.bus_idle_timeout_enable & core_r.cfg.busy & lines_high & tick
    & (core_r.free_cnt == SBC_FREE_PERIODS);
  assign hold_len = core_r.cfg.sda_timing_extend ? SBC_HOLD_EXT : SBC_HOLD_STD;
  assign setup_len = core_r.cfg.sda_timing_extend ? SBC_SETUP_EXT : SBC_SETUP_STD;
  // As transmitter, data bits come from the shifter; as receiver, the ack bit comes from the ack register
  assign bit_one = (core_r.bit_cnt < SBC_ACK_BIT) ? (~core_r.ctl.transmitter_role | core_r.shift[7])
    : (core_r.ctl.transmitter_role | ~core_r.ctl.ack);

  // Status vector: role bits and condition flags in the top nibble
  always_comb begin
    ctl_view = core_r.ctl;
    ctl_view.begin_condition_flag = core_r.ctl.begin_condition_flag | core_r.begin_seen;
    ctl_view.halt_condition_flag = core_r.ctl.halt_condition_flag | core_r.halt_seen;
  end

  // Read selection, unmapped addresses read zero
  assign rdata_nxt = (i_sfr_addr == SBC_CONTROL_ADDR) ? ctl_view
    : (i_sfr_addr == SBC_CONFIG_ADDR) ? core_r.cfg
    : (i_sfr_addr == SBC_DATA_ADDR) ? core_r.shift : 8'h00;

  // ************************************************************
  // Controller next state
  // ************************************************************
  // Software effects first, hardware sets after, so a set beats a clear
  always_comb begin
    core_nxt = core_r;
    core_nxt.timer3_reload = core_r.cfg.enable & core_r.cfg.scl_low_timeout_enable & lvl_r.scl;
    if (write_cfg) begin
      core_nxt.cfg = cfg_wdata;
      core_nxt.cfg.busy = core_r.cfg.busy;
    end
    if (write_ctl) begin
      core_nxt.ctl.begin_condition_flag = ctl_wdata.begin_condition_flag;
      core_nxt.ctl.halt_condition_flag = ctl_wdata.halt_condition_flag;
      core_nxt.ctl.ack = ctl_wdata.ack;
      core_nxt.ctl.irq_flag = ctl_wdata.irq_flag;
    end
    if (write_data) begin
      core_nxt.shift = i_sfr_wdata;
    end
    if (irq_clear) begin
      core_nxt.ctl.arbitration_dropped = 1'b0;
      core_nxt.ctl.ack_value_needed = 1'b0;
      core_nxt.begin_seen = 1'b0;
      core_nxt.halt_seen = 1'b0;
      core_nxt.bus_error = 1'b0;
    end
    // Bus watch: busy flag and free timeout
    if (begin_ev) begin
      core_nxt.begin_seen = 1'b1;
      core_nxt.cfg.busy = 1'b1;
    end
    if (halt_ev) begin
      core_nxt.halt_seen = 1'b1;
      core_nxt.cfg.busy = 1'b0;
    end
    if (!(core_r.cfg.bus_idle_timeout_enable & core_r.cfg.busy & lines_high)) begin
      core_nxt.free_cnt = 4'h0;
    end else if (tick && core_r.free_cnt != SBC_FREE_PERIODS) begin
      core_nxt.free_cnt = core_r.free_cnt + 4'h1;
    end
    if (free_ev) begin
      core_nxt.cfg.busy = 1'b0;
      core_nxt.halt_seen = 1'b1;
      core_nxt.ctl.irq_flag = 1'b1;
    end
    case (core_r.state)
      SBC_IDLE: begin
        core_nxt.scl_pull = 1'b0;
        core_nxt.sda_pull = 1'b0;
        if (core_r.cfg.enable && core_r.ctl.begin_condition_flag && !core_r.cfg.busy && lines_high) begin
          core_nxt.state = SBC_START;
        end
      end
      SBC_START: begin
        core_nxt.sda_pull = 1'b1;
        // Clock only falls once the data line is seen low, else the START is not a START
        if (tick && !lvl_r.sda) begin
          // Begin flag is left alone; software clears it
          core_nxt.scl_pull = 1'b1;
          core_nxt.ctl.controller_role = 1'b1;
          core_nxt.ctl.transmitter_role = 1'b1;
          core_nxt.ctl.irq_flag = 1'b1;
          core_nxt.cfg.busy = 1'b1;
          core_nxt.first_byte = 1'b1;
          core_nxt.bit_cnt = 4'h0;
          core_nxt.state = SBC_WAIT;
        end
      end
      SBC_LOW: begin
        // Hold delay counts from the clock seen low, so a stale high level never releases it early
        if (!lvl_r.scl && core_r.phase != SBC_PHASE_MAX) begin
          core_nxt.phase = core_r.phase + 5'h01;
        end
        if (tick) begin
          core_nxt.tick_seen = 1'b1;
        end
        if (core_r.phase == hold_len) begin
          core_nxt.sda_pull = ~bit_one;
        end
        if (core_r.phase > hold_len && (!core_r.ctl.controller_role
            || (core_r.phase >= hold_len + setup_len && core_r.tick_seen))) begin
          core_nxt.scl_pull = 1'b0;
          core_nxt.sampled = 1'b0;
          core_nxt.state = SBC_HIGH;
        end
      end
      SBC_HIGH: begin
        if (!core_r.sampled && lvl_r.scl) begin
          core_nxt.sampled = 1'b1;
          if (core_r.bit_cnt < SBC_ACK_BIT) begin
            core_nxt.shift = {core_r.shift[6:0], lvl_r.sda};
            if (core_r.ctl.transmitter_role && !core_r.sda_pull && !lvl_r.sda) begin
              core_nxt.ctl.arbitration_dropped = 1'b1;
              core_nxt.bus_error = core_r.slave_active;
              core_nxt.ctl.irq_flag = 1'b1;
              core_nxt.ctl.controller_role = 1'b0;
              core_nxt.slave_active = 1'b0;
              core_nxt.sda_pull = 1'b0;
              core_nxt.state = SBC_IDLE;
            end
          end else if (core_r.ctl.transmitter_role) begin
            core_nxt.ctl.ack = ~lvl_r.sda;
          end
        end else if (core_r.sampled && (core_r.ctl.controller_role ? tick : !lvl_r.scl)) begin
          // Clock seen low again as slave, or bit clock tick as controller: close this bit
          core_nxt.scl_pull = core_r.ctl.controller_role;
          core_nxt.phase = 5'h00;
          core_nxt.tick_seen = 1'b0;
          core_nxt.bit_cnt = core_r.bit_cnt + 4'h1;
          core_nxt.state = SBC_LOW;
          if (core_r.bit_cnt == SBC_LAST_DATA_BIT && !core_r.ctl.transmitter_role) begin
            core_nxt.ctl.ack_value_needed = 1'b1;
            core_nxt.ctl.ack = 1'b0;
            core_nxt.ctl.irq_flag = 1'b1;
            core_nxt.scl_pull = 1'b1;
            core_nxt.state = SBC_WAIT;
          end else if (core_r.bit_cnt == SBC_ACK_BIT) begin
            core_nxt.bit_cnt = 4'h0;
            core_nxt.first_byte = 1'b0;
            if (core_r.slave_active && core_r.first_byte && !core_r.ctl.transmitter_role && !core_r.ctl.ack) begin
              core_nxt.slave_active = 1'b0;
              core_nxt.scl_pull = 1'b0;
              core_nxt.sda_pull = 1'b0;
              core_nxt.state = SBC_IDLE;
            end else if (core_r.ctl.transmitter_role || (core_r.slave_active && core_r.first_byte && core_r.shift[0])) begin
              core_nxt.ctl.irq_flag = 1'b1;
              core_nxt.scl_pull = 1'b1;
              core_nxt.sda_pull = 1'b0;
              core_nxt.state = SBC_WAIT;
              if (core_r.first_byte && core_r.shift[0] && (core_r.slave_active || core_r.ctl.ack)) begin
                core_nxt.ctl.transmitter_role = core_r.slave_active;
              end
            end else if (core_r.ctl.controller_role && core_r.ctl.halt_condition_flag) begin
              core_nxt.state = SBC_STOP;
            end else if (core_r.ctl.controller_role && core_r.ctl.begin_condition_flag) begin
              core_nxt.state = SBC_RESTART;
            end
          end
        end
      end
      SBC_WAIT: begin
        core_nxt.scl_pull = 1'b1;
        if (core_r.ctl.ack_value_needed) begin
          core_nxt.sda_pull = core_nxt.ctl.ack;
        end
        if (!core_r.ctl.irq_flag) begin
          core_nxt.phase = 5'h00;
          core_nxt.tick_seen = 1'b0;
          core_nxt.state = SBC_LOW;
          // An ack still owed is sent before any STOP
          if (core_r.ctl.controller_role && core_r.bit_cnt != SBC_ACK_BIT) begin
            if (core_r.ctl.halt_condition_flag) begin
              core_nxt.state = SBC_STOP;
            end else if (core_r.ctl.begin_condition_flag) begin
              core_nxt.state = SBC_RESTART;
            end
          end
        end
      end
      SBC_STOP: begin
        if (core_r.phase != SBC_PHASE_MAX) begin
          core_nxt.phase = core_r.phase + 5'h01;
        end
        if (core_r.scl_pull) begin
          core_nxt.sda_pull = 1'b1;
          if (tick && core_r.phase > hold_len) begin
            core_nxt.scl_pull = 1'b0;
          end
        end else if (lvl_r.scl && tick) begin
          // Idle then sees a set begin flag again: STOP then START
          core_nxt.sda_pull = 1'b0;
          core_nxt.ctl.controller_role = 1'b0;
          core_nxt.ctl.halt_condition_flag = 1'b0;
          core_nxt.state = SBC_IDLE;
        end
      end
      SBC_RESTART: begin
        if (core_r.phase != SBC_PHASE_MAX) begin
          core_nxt.phase = core_r.phase + 5'h01;
        end
        if (core_r.scl_pull) begin
          core_nxt.sda_pull = 1'b0;
          if (tick && core_r.phase > hold_len) begin
            core_nxt.scl_pull = 1'b0;
          end
        end else if (lines_high && tick) begin
          core_nxt.state = SBC_START;
        end
      end
      default: begin
        core_nxt.state = SBC_IDLE;
      end
    endcase
    // Slave events: address phase after a START seen while idle or addressed and not inhibited, end on STOP or timeout
    if (core_r.slave_active && (halt_ev || free_ev)) begin
      core_nxt.ctl.irq_flag = 1'b1;
      core_nxt.slave_active = 1'b0;
      core_nxt.scl_pull = 1'b0;
      core_nxt.sda_pull = 1'b0;
      core_nxt.state = SBC_IDLE;
    end else if (begin_ev && core_r.cfg.enable && !core_r.cfg.slave_inhibit && !core_r.ctl.controller_role
        && (core_r.state == SBC_IDLE || core_r.slave_active)) begin
      core_nxt.slave_active = 1'b1;
      core_nxt.ctl.transmitter_role = 1'b0;
      core_nxt.first_byte = 1'b1;
      core_nxt.bit_cnt = 4'h0;
      core_nxt.phase = 5'h00;
      core_nxt.sda_pull = 1'b0;
      core_nxt.state = SBC_LOW;
    end
    if (!core_r.cfg.enable) begin
      core_nxt.ctl.controller_role = 1'b0;
      core_nxt.slave_active = 1'b0;
      core_nxt.scl_pull = 1'b0;
      core_nxt.sda_pull = 1'b0;
      core_nxt.state = SBC_IDLE;
    end
  end

  // ************************************************************
  // System registers
  // ************************************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      core_r <= SBC_CORE_RESET;
      rdata_r <= 8'h00;
    end else begin
      core_r <= core_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_sfr_rdata = rdata_r;
  assign o_bus_error = core_r.bus_error;
  assign o_timer3_reload = core_r.timer3_reload;

endmodule : sbc_controller
`default_nettype wire

/* File: sbc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module sbc_monitor (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_write,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_scl_in,
  input wire logic o_timer3_reload,
  input wire logic o_bus_error
);
  import sbc_pkg::*;
  logic [7:0] cfg_r;
  logic [4:0] on_r;
  logic [4:0] off_r;
  wire irq_clr = i_sfr_write && i_sfr_addr == SBC_CONTROL_ADDR && !i_sfr_wdata[0];
  wire t3_on = i_scl_in && cfg_r[7] && cfg_r[3];
  // Config shadow and settle counters; the two-domain sync lag stays under 20 clocks
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cfg_r <= 8'h00;
      on_r <= 5'h00;
      off_r <= 5'h00;
    end else begin
      if (i_sfr_write && i_sfr_addr == SBC_CONFIG_ADDR) cfg_r <= i_sfr_wdata;
      on_r <= !t3_on ? 5'h00 : (on_r == 5'h1F ? on_r : on_r + 5'h01);
      off_r <= t3_on ? 5'h00 : (off_r == 5'h1F ? off_r : off_r + 5'h01);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  property p_reset_clean;
    $fell(i_reset) |-> o_sfr_rdata == 8'h00 && !o_bus_error && !o_timer3_reload;
  endproperty
  a_reset_clean: assert property (p_reset_clean) else $error("state not clear after reset");
  property p_unmapped;
    $past(i_sfr_addr) < SBC_CONTROL_ADDR || $past(i_sfr_addr) > SBC_DATA_ADDR |-> o_sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cfg_back;
    $past(i_sfr_addr) == SBC_CONFIG_ADDR |-> (o_sfr_rdata & 8'hDF) == ($past(cfg_r) & 8'hDF);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
  property p_t3_off;
    off_r >= 5'h14 |-> !o_timer3_reload;
  endproperty
  a_t3_off: assert property (p_t3_off) else $error("reload while clock low");
  property p_t3_on;
    on_r >= 5'h14 |-> o_timer3_reload;
  endproperty
  a_t3_on: assert property (p_t3_on) else $error("no reload while clock high");
  property p_err_clear;
    irq_clr |=> !o_bus_error;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("bus error kept");
  property p_err_hold;
    o_bus_error && !irq_clr |=> o_bus_error;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("bus error dropped");
  property p_begin_hold;
    i_sfr_addr == SBC_CONTROL_ADDR && !i_sfr_write && !$past(i_sfr_write)
      && $past(i_sfr_addr) == SBC_CONTROL_ADDR && o_sfr_rdata[5] |=> o_sfr_rdata[5];
  endproperty
  a_begin_hold: assert property (p_begin_hold) else $error("begin flag cleared");
  c_irq: cover property ($past(i_sfr_addr) == SBC_CONTROL_ADDR && o_sfr_rdata[0]);
  c_master: cover property ($past(i_sfr_addr) == SBC_CONTROL_ADDR && o_sfr_rdata[7]);
  c_reload: cover property ($rose(o_timer3_reload));
endmodule : sbc_monitor
bind sbc_controller sbc_monitor u_sbc_monitor (
  .i_clock(i_clock), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr),
  .i_sfr_write(i_sfr_write), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
  .i_scl_in(i_scl_in), .o_timer3_reload(o_timer3_reload), .o_bus_error(o_bus_error)
);
`default_nettype wire

/* File: sbc_pkg.sv */
`default_nettype none
package sbc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] SBC_CONTROL_ADDR = 8'hC0;
  localparam logic [7:0] SBC_CONFIG_ADDR = 8'hC1;
  localparam logic [7:0] SBC_DATA_ADDR = 8'hC2;
  localparam logic [7:0] SBC_CONFIG_RESET = 8'h00;
  localparam logic [7:0] SBC_CONTROL_RESET = 8'h00;

  // ************************************************************
  // Timing, in system clocks and bit clock periods
  // ************************************************************
  localparam logic [4:0] SBC_HOLD_STD = 5'h03;
  localparam logic [4:0] SBC_HOLD_EXT = 5'h0C;
  localparam logic [4:0] SBC_SETUP_STD = 5'h01;
  localparam logic [4:0] SBC_SETUP_EXT = 5'h0B;
  localparam logic [4:0] SBC_PHASE_MAX = 5'h1F;
  localparam logic [3:0] SBC_FREE_PERIODS = 4'hA;
  localparam logic [3:0] SBC_ACK_BIT = 4'h8;
  localparam logic [3:0] SBC_LAST_DATA_BIT = 4'h7;

  // ************************************************************
  // Types
  // ************************************************************
  // Configuration register, bit 7 down to bit 0
  typedef struct packed {
    logic enable;
    logic slave_inhibit;
    logic busy;
    logic sda_timing_extend;
    logic scl_low_timeout_enable;
    logic bus_idle_timeout_enable;
    logic [1:0] bit_clock_select;
  } sbc_config_type;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic controller_role;
    logic transmitter_role;
    logic begin_condition_flag;
    logic halt_condition_flag;
    logic ack_value_needed;
    logic arbitration_dropped;
    logic ack;
    logic irq_flag;
  } sbc_control_type;

  // Bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } sbc_lines_type;

  // Gray codes along idle, start, low, high, wait, stop, restart
  typedef enum logic [2:0] {
    SBC_IDLE = 3'h0,
    SBC_START = 3'h1,
    SBC_LOW = 3'h3,
    SBC_HIGH = 3'h2,
    SBC_WAIT = 3'h6,
    SBC_STOP = 3'h7,
    SBC_RESTART = 3'h5
  } sbc_state_type;

  // System-side state of the controller, apart from the synchronisers and the read data register
  typedef struct packed {
    sbc_state_type state;
    sbc_config_type cfg;
    sbc_control_type ctl;
    logic begin_seen;
    logic halt_seen;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [4:0] phase;
    logic [3:0] free_cnt;
    logic tick_seen;
    logic sampled;
    logic first_byte;
    logic slave_active;
    logic scl_pull;
    logic sda_pull;
    logic bus_error;
    logic timer3_reload;
  } sbc_core_type;

  localparam sbc_core_type SBC_CORE_RESET = '0;

endpackage : sbc_pkg
`default_nettype wire

/* File: sbc_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sbc_slave_model #(
  parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
  // Resolved bus lines
  input wire logic i_scl,
  input wire logic i_sda,
  // Data pull-down and last byte taken
  output logic o_sda_oe,
  output logic [7:0] o_last_byte
);
  logic [7:0] shift_r;
  logic match_r;
  logic first_r;
  // One frame per START; a STOP aborts it so the line is never left pulled
  initial begin
    o_sda_oe = 1'b0;
    o_last_byte = 8'h00;
    forever begin
      @(negedge i_sda iff i_scl);
      first_r = 1'b1;
      match_r = 1'b0;
      fork
        forever begin
          repeat (8) begin
            @(posedge i_scl);
            shift_r = {shift_r[6:0], i_sda};
          end
          if (first_r) match_r = shift_r[7:1] == TARGET_ADDR;
          else o_last_byte = shift_r;
          first_r = 1'b0;
          @(negedge i_scl);
          o_sda_oe = match_r;
          @(negedge i_scl);
          o_sda_oe = 1'b0;
        end
        @(posedge i_sda iff i_scl);
      join_any
      disable fork;
      o_sda_oe = 1'b0;
    end
  end
endmodule : sbc_slave_model
`default_nettype wire

/* File: smbus_controller_status_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module smbus_controller_status_control_tb_top;
  import sbc_pkg::*;
  logic i_clock, i_reset, i_sfr_write, link_clock, slave_oe, o_timer3_reload, o_bus_error;
  logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, rd_v, last_byte;
  logic [3:0] tick;
  int fail_count = 0;
  int samples_checked = 0;
  // Open-drain lines with pull-ups
  wire scl_w = !o_scl_oe;
  wire sda_w = !(o_sda_oe || slave_oe);
  sbc_controller u_sbc_controller (.i_clock(i_clock), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr),
    .i_sfr_write(i_sfr_write), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_timer_overflow(tick), .o_timer3_reload(o_timer3_reload), .o_bus_error(o_bus_error),
    .i_link_clock(link_clock), .i_scl_in(scl_w), .i_sda_in(sda_w), .o_scl_out(o_scl_out),
    .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe));
  sbc_slave_model u_sbc_slave_model (.i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(slave_oe),
    .o_last_byte(last_byte));
  // Clocks; the link clock is offset so the phases never line up
  initial begin i_clock = 1'b0; forever #25 i_clock = ~i_clock; end
  initial begin link_clock = 1'b0; #37; forever #80 link_clock = ~link_clock; end
  // Bit clock ticks every eight system clocks on all four sources
  initial begin tick = 4'h0; forever begin repeat (7) @(negedge i_clock); tick = 4'hF; @(negedge i_clock); tick = 4'h0; end end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_write = 1'b1;
    @(negedge i_clock);
    i_sfr_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge i_clock);
    i_sfr_addr = a;
    @(negedge i_clock);
    rd_v = o_sfr_rdata;
  endtask : rd
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    rd(a);
    while (rd_v[b] !== v && n < 3000) begin rd(a); n++; end
    `CHK("wait bit", v, rd_v[b])
  endtask : wait_bit
  task automatic t_regs();
    rd(8'h55); `CHK("unmapped", 8'h00, rd_v)
    wr(SBC_CONFIG_ADDR, 8'h20); rd(SBC_CONFIG_ADDR); `CHK("busy ro", 8'h00, rd_v)
    wr(SBC_CONTROL_ADDR, 8'hCC); rd(SBC_CONTROL_ADDR); `CHK("ctl ro", 8'h00, rd_v)
    wr(SBC_CONFIG_ADDR, 8'h99); rd(SBC_CONFIG_ADDR); `CHK("cfg", 8'h99, rd_v)
  endtask : t_regs
  // Address, optional data byte, then STOP; SCL must stay low while the flag is up
  // The vector includes a STOP seen since the last interrupt, so callers give it
  task automatic t_master(input logic [7:0] ab, input logic ack, input logic [7:0] vec);
    wr(SBC_CONTROL_ADDR, 8'h20); wait_bit(SBC_CONTROL_ADDR, 0, 1'b1);
    `CHK("vector", vec, rd_v & 8'hF0)
    repeat (40) @(negedge i_clock);
    `CHK("stall", 1'b0, scl_w)
    wr(SBC_DATA_ADDR, ab); wr(SBC_CONTROL_ADDR, 8'h00); wait_bit(SBC_CONTROL_ADDR, 0, 1'b1);
    `CHK("ack", ack, rd_v[1])
    if (ack) begin
      wr(SBC_DATA_ADDR, 8'h5A);
      wr(SBC_CONTROL_ADDR, 8'h00);
      wait_bit(SBC_CONTROL_ADDR, 0, 1'b1);
      `CHK("byte", 8'h5A, last_byte)
    end
    wr(SBC_CONTROL_ADDR, 8'h10); wait_bit(SBC_CONFIG_ADDR, 5, 1'b0);
    rd(SBC_CONTROL_ADDR); `CHK("after stop", 8'h10, rd_v & 8'h90)
    `CHK("idle", 2'b11, {scl_w, sda_w})
  endtask : t_master
  task automatic wrap_up();
    $display("Checks %0d, failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // Watchdog well beyond the longest polling span
  initial begin repeat (60000) @(posedge i_clock); fail_count++; wrap_up(); end
  initial begin
    i_reset = 1'b1;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    i_sfr_write = 1'b0;
    repeat (12) @(negedge i_clock);
    i_reset = 1'b0;
    t_regs();
    t_master(8'h54, 1'b1, 8'hE0);
    t_master(8'h22, 1'b0, 8'hF0);
    wrap_up();
  end
endmodule : smbus_controller_status_control_tb_top
`default_nettype wire
